// file: src/ltcs_regs.vh
// Register map and timing constants of the leak-test cycle sequencer.
`ifndef LTCS_REGS_VH
`define LTCS_REGS_VH

// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define LTCS_OFF_CTRL      8'h00
`define LTCS_OFF_STATUS    8'h04
`define LTCS_OFF_IRQ_STAT  8'h08
`define LTCS_OFF_IRQ_MASK  8'h0C
`define LTCS_OFF_SETPOINT  8'h10
`define LTCS_OFF_BG_LIMIT  8'h14
`define LTCS_OFF_DELAY     8'h18
`define LTCS_OFF_TEST      8'h1C
`define LTCS_OFF_BG_TMO    8'h20
`define LTCS_OFF_EVAC      8'h24
`define LTCS_OFF_VENT      8'h28
`define LTCS_OFF_RESULT    8'h2C

// -----------------------------------------------------------------------------
// Control fields
// -----------------------------------------------------------------------------
`define LTCS_CTRL_START    0
`define LTCS_CTRL_FILL_EN  1
`define LTCS_CTRL_PEAK     2
`define LTCS_CTRL_ABORT    3

// -----------------------------------------------------------------------------
// Interrupt bits
// -----------------------------------------------------------------------------
`define LTCS_IRQ_DONE      0
`define LTCS_IRQ_FAIL      1
`define LTCS_IRQ_WARN      2

// -----------------------------------------------------------------------------
// Reset values and codes
// -----------------------------------------------------------------------------
`define LTCS_RST_SETPOINT  32'h0000_1000
`define LTCS_RST_BG_LIMIT  32'hFFFF_FFFF
`define LTCS_RST_TIMER     16'h000A
`define LTCS_WARN_BG_TMO   8'hA3

// -----------------------------------------------------------------------------
// Time base
// -----------------------------------------------------------------------------
`define LTCS_CLK_HZ        20000000
`define LTCS_TICK_US       1000
`define LTCS_TICK_CYCLES   ((`LTCS_CLK_HZ / 1000000) * `LTCS_TICK_US)

`endif

// file: src/ltcs_timer.v
// Down-counting cycle timer running on the common tick.
`timescale 1ns/1ps
`default_nettype none

module ltcs_timer #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // Control
  input  wire             load,
  input  wire [WIDTH-1:0] value,
  input  wire             tick,
  // Status
  output wire             expired
);

  reg [WIDTH-1:0] count_reg;
  reg             run_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= {WIDTH{1'b0}};
      run_reg   <= 1'b0;
    end else if (load) begin
      count_reg <= value;
      run_reg   <= 1'b1;
    end else if (run_reg && tick && count_reg != {WIDTH{1'b0}}) begin
      count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign expired = run_reg && !load && count_reg == {WIDTH{1'b0}};

endmodule

`default_nettype wire

// file: src/ltcs_seq.v
// Leak-test cycle sequencer with AHB-Lite register slave.
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ltcs_regs.vh"

// How it works
// - A cycle runs evacuation, optional filling, measurement and venting in order.
// - The settling delay timer is loaded when the highest sensitivity range is first reached.
// - The cycle holds in the settling step until the delay has fully expired.
// - The delay sits inside every cycle that reaches the highest range without an abort, so no such cycle ends sooner than the delay.
// - The measuring interval lasts the programmed test duration.
// - Filling, or measuring when filling is disabled, does not start while the background is at or above the limit.
// - The background wait is bounded by a timeout that aborts with warning code 163.
// - With filling enabled, fill request rises once the background condition is met.
// - With filling disabled, fill request stays low and fill done is ignored.
// - In final-sample mode the decision uses the rate sampled at interval end.
// - In peak mode the decision uses the largest rate seen during the interval.
// - The result is FAIL above the setpoint and PASS at or below it.
module ltcs_seq #(
  parameter TW        = 16,
  parameter TICK_CYC  = `LTCS_TICK_CYCLES
) (
  // AHB-Lite
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Measurement front end
  input  wire        high_range_in,
  input  wire [31:0] leak_rate,
  // Filling station
  input  wire        fill_done_in,
  output reg         fill_req,
  // Chamber control
  output reg         evac_on,
  output reg         vent_on,
  // Result and interrupt
  output reg         pass_out,
  output reg         fail_out,
  output reg         irq
);

  // ---------------------------------------------------------------------------
  // States
  // ---------------------------------------------------------------------------
  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_EVAC   = 3'h1;
  localparam [2:0] S_SETTLE = 3'h2;
  localparam [2:0] S_BGWAIT = 3'h3;
  localparam [2:0] S_FILL   = 3'h4;
  localparam [2:0] S_MEAS   = 3'h5;
  localparam [2:0] S_VENT   = 3'h6;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  reg [1:0] range_sync_reg;
  reg [1:0] done_sync_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      range_sync_reg <= 2'h0;
      done_sync_reg  <= 2'h0;
    end else begin
      range_sync_reg <= {range_sync_reg[0], high_range_in};
      done_sync_reg  <= {done_sync_reg[0], fill_done_in};
    end
  end

  wire highest_sensitivity_range = range_sync_reg[1];
  wire fill_done                 = done_sync_reg[1];

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  reg        fill_en_reg;
  reg        peak_mode_reg;
  reg [2:0]  irq_stat_reg;
  reg [2:0]  irq_mask_reg;
  reg [31:0] setpoint_reg;
  reg [31:0] bg_limit_reg;
  reg [TW-1:0] delay_reg;
  reg [TW-1:0] test_reg;
  reg [TW-1:0] bg_tmo_reg;
  reg [TW-1:0] evac_reg;
  reg [TW-1:0] vent_reg;
  reg [31:0] result_reg;
  reg [7:0]  warn_reg;
  reg [2:0]  state_reg;
  reg [31:0] peak_reg;
  reg        start_pulse;
  reg        abort_pulse;

  // ---------------------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------------------
  reg [31:0] div_reg;
  reg        tick;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (div_reg == TICK_CYC - 1) begin
      div_reg <= 32'h0;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h1;
      tick    <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Cycle timers
  // ---------------------------------------------------------------------------
  reg [2:0] prev_state_reg;
  wire      entered = state_reg != prev_state_reg;
  reg       tmr_load;
  reg [TW-1:0] tmr_value;
  wire      tmr_exp;

  always @* begin
    tmr_load = entered;
    case (state_reg)
      S_EVAC:   tmr_value = evac_reg;
      S_SETTLE: tmr_value = delay_reg;
      S_BGWAIT: tmr_value = bg_tmo_reg;
      S_MEAS:   tmr_value = test_reg;
      S_VENT:   tmr_value = vent_reg;
      default:  tmr_value = {TW{1'b0}};
    endcase
    // The settling delay starts only once the range is reached.
    if (state_reg == S_SETTLE)
      tmr_load = entered;
  end

  ltcs_timer #(.WIDTH(TW)) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (tmr_load),
    .value   (tmr_value),
    .tick    (tick),
    .expired (tmr_exp)
  );

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  wire bg_ok    = leak_rate < bg_limit_reg;
  wire meas_end = state_reg == S_MEAS && !entered && tmr_exp;
  wire [31:0] final_val = peak_mode_reg ?
                          ((leak_rate > peak_reg) ? leak_rate : peak_reg) : leak_rate;
  wire is_fail  = final_val > setpoint_reg;
  reg  ev_done;
  reg  ev_fail;
  reg  ev_warn;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg      <= S_IDLE;
      prev_state_reg <= S_IDLE;
      peak_reg       <= 32'h0;
      result_reg     <= 32'h0;
      warn_reg       <= 8'h0;
      fill_req       <= 1'b0;
      evac_on        <= 1'b0;
      vent_on        <= 1'b0;
      pass_out       <= 1'b0;
      fail_out       <= 1'b0;
      ev_done        <= 1'b0;
      ev_fail        <= 1'b0;
      ev_warn        <= 1'b0;
    end else begin
      prev_state_reg <= state_reg;
      ev_done        <= 1'b0;
      ev_fail        <= 1'b0;
      ev_warn        <= 1'b0;
      if (state_reg == S_MEAS && !entered && leak_rate > peak_reg)
        peak_reg <= leak_rate;
      if (abort_pulse && state_reg != S_IDLE && state_reg != S_VENT) begin
        fill_req  <= 1'b0;
        evac_on   <= 1'b0;
        vent_on   <= 1'b1;
        state_reg <= S_VENT;
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (start_pulse) begin
              pass_out  <= 1'b0;
              fail_out  <= 1'b0;
              warn_reg  <= 8'h0;
              evac_on   <= 1'b1;
              state_reg <= S_EVAC;
            end
          end
          S_EVAC: begin
            if (highest_sensitivity_range)
              state_reg <= S_SETTLE;
            else if (!entered && tmr_exp) begin
              evac_on   <= 1'b0;
              vent_on   <= 1'b1;
              state_reg <= S_VENT;
            end
          end
          S_SETTLE: begin
            if (!entered && tmr_exp)
              state_reg <= S_BGWAIT;
          end
          S_BGWAIT: begin
            if (bg_ok) begin
              if (fill_en_reg) begin
                fill_req  <= 1'b1;
                state_reg <= S_FILL;
              end else begin
                peak_reg  <= 32'h0;
                state_reg <= S_MEAS;
              end
            end else if (!entered && tmr_exp) begin
              warn_reg  <= `LTCS_WARN_BG_TMO;
              ev_warn   <= 1'b1;
              evac_on   <= 1'b0;
              vent_on   <= 1'b1;
              state_reg <= S_VENT;
            end
          end
          S_FILL: begin
            if (fill_done) begin
              fill_req  <= 1'b0;
              peak_reg  <= 32'h0;
              state_reg <= S_MEAS;
            end
          end
          S_MEAS: begin
            if (meas_end) begin
              result_reg <= final_val;
              pass_out   <= !is_fail;
              fail_out   <= is_fail;
              ev_fail    <= is_fail;
              evac_on    <= 1'b0;
              vent_on    <= 1'b1;
              state_reg  <= S_VENT;
            end
          end
          S_VENT: begin
            if (!entered && tmr_exp) begin
              vent_on   <= 1'b0;
              ev_done   <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------------------
  reg       wr_pend_reg;
  reg [7:0] addr_reg;
  wire      take = hsel && hready && htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h0;
    end else begin
      wr_pend_reg <= take && hwrite;
      if (take)
        addr_reg <= haddr[7:0];
    end
  end

  wire [2:0] irq_set = {ev_warn, ev_fail, ev_done};
  wire       clr_wr  = wr_pend_reg && addr_reg == `LTCS_OFF_IRQ_STAT;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fill_en_reg   <= 1'b0;
      peak_mode_reg <= 1'b0;
      start_pulse   <= 1'b0;
      abort_pulse   <= 1'b0;
      irq_stat_reg  <= 3'h0;
      irq_mask_reg  <= 3'h0;
      setpoint_reg  <= `LTCS_RST_SETPOINT;
      bg_limit_reg  <= `LTCS_RST_BG_LIMIT;
      delay_reg     <= `LTCS_RST_TIMER;
      test_reg      <= `LTCS_RST_TIMER;
      bg_tmo_reg    <= `LTCS_RST_TIMER;
      evac_reg      <= `LTCS_RST_TIMER;
      vent_reg      <= `LTCS_RST_TIMER;
      irq           <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      abort_pulse <= 1'b0;
      // Hardware set wins over a write-one clear in the same cycle.
      irq_stat_reg <= (irq_stat_reg & ~(clr_wr ? hwdata[2:0] : 3'h0)) | irq_set;
      irq          <= |(irq_stat_reg & irq_mask_reg);
      if (wr_pend_reg) begin
        case (addr_reg)
          `LTCS_OFF_CTRL: begin
            start_pulse   <= hwdata[`LTCS_CTRL_START];
            fill_en_reg   <= hwdata[`LTCS_CTRL_FILL_EN];
            peak_mode_reg <= hwdata[`LTCS_CTRL_PEAK];
            abort_pulse   <= hwdata[`LTCS_CTRL_ABORT];
          end
          `LTCS_OFF_IRQ_MASK: irq_mask_reg <= hwdata[2:0];
          `LTCS_OFF_SETPOINT: setpoint_reg <= hwdata;
          `LTCS_OFF_BG_LIMIT: bg_limit_reg <= hwdata;
          `LTCS_OFF_DELAY:    delay_reg    <= hwdata[TW-1:0];
          `LTCS_OFF_TEST:     test_reg     <= hwdata[TW-1:0];
          `LTCS_OFF_BG_TMO:   bg_tmo_reg   <= hwdata[TW-1:0];
          `LTCS_OFF_EVAC:     evac_reg     <= hwdata[TW-1:0];
          `LTCS_OFF_VENT:     vent_reg     <= hwdata[TW-1:0];
          default: ;
        endcase
      end
    end
  end

  reg [31:0] rd_mux;

  always @* begin
    case (haddr[7:0])
      `LTCS_OFF_CTRL:     rd_mux = {29'h0, peak_mode_reg, fill_en_reg, 1'b0};
      `LTCS_OFF_STATUS:   rd_mux = {16'h0, warn_reg, 1'b0, state_reg,
                                    fill_req, fail_out, pass_out, 1'b0};
      `LTCS_OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
      `LTCS_OFF_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
      `LTCS_OFF_SETPOINT: rd_mux = setpoint_reg;
      `LTCS_OFF_BG_LIMIT: rd_mux = bg_limit_reg;
      `LTCS_OFF_DELAY:    rd_mux = {{(32-TW){1'b0}}, delay_reg};
      `LTCS_OFF_TEST:     rd_mux = {{(32-TW){1'b0}}, test_reg};
      `LTCS_OFF_BG_TMO:   rd_mux = {{(32-TW){1'b0}}, bg_tmo_reg};
      `LTCS_OFF_EVAC:     rd_mux = {{(32-TW){1'b0}}, evac_reg};
      `LTCS_OFF_VENT:     rd_mux = {{(32-TW){1'b0}}, vent_reg};
      `LTCS_OFF_RESULT:   rd_mux = result_reg;
      default:            rd_mux = 32'h0;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (take && !hwrite)
        hrdata <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// file: verification/ltcs_props.sv
// Port-level checker of the leak-test cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
module ltcs_props #(
  parameter TW       = 16,
  parameter TICK_CYC = 4
) (
  // AHB-Lite
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Front end and filling station
  input wire logic        high_range_in,
  input wire logic [31:0] leak_rate,
  input wire logic        fill_done_in,
  input wire logic        fill_req,
  // Chamber, result, interrupt
  input wire logic        evac_on,
  input wire logic        vent_on,
  input wire logic        pass_out,
  input wire logic        fail_out,
  input wire logic        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------------------
  sequence s_settle_start;
    $rose(high_range_in) && evac_on && !vent_on;
  endsequence
  sequence s_quiet;
    !fill_req [*8];
  endsequence
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  property p_ready;
    hreadyout && !hresp;
  endproperty
  property p_excl;
    !(evac_on && vent_on);
  endproperty
  property p_evac_hold;
    evac_on && !high_range_in && !$past(high_range_in) && !$past(high_range_in, 2)
      |=> evac_on || vent_on;
  endproperty
  property p_fill_phase;
    fill_req |-> evac_on && !vent_on;
  endproperty
  property p_result;
    !(pass_out && fail_out);
  endproperty
  property p_clear;
    $rose(evac_on) |-> ##[0:1] (!pass_out && !fail_out);
  endproperty
  property p_res_end;
    ($rose(pass_out) || $rose(fail_out)) |-> ##[0:2] vent_on;
  endproperty
  property p_settle;
    s_settle_start |-> s_quiet;
  endproperty
  a_ready: assert property (p_ready) else $error("bus answer not zero-wait OKAY");
  a_excl: assert property (p_excl) else $error("evacuate and vent together");
  a_evac_hold: assert property (p_evac_hold) else $error("evacuation left early");
  a_fill_phase: assert property (p_fill_phase) else $error("fill request out of step");
  a_result: assert property (p_result) else $error("pass and fail together");
  a_clear: assert property (p_clear) else $error("result not cleared at start");
  a_res_end: assert property (p_res_end) else $error("result without venting");
  a_settle: assert property (p_settle) else $error("settling delay cut short");
endmodule
bind ltcs_seq ltcs_props #(.TW(TW), .TICK_CYC(TICK_CYC)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .high_range_in(high_range_in),
  .leak_rate(leak_rate), .fill_done_in(fill_done_in), .fill_req(fill_req),
  .evac_on(evac_on), .vent_on(vent_on), .pass_out(pass_out), .fail_out(fail_out),
  .irq(irq));
`default_nettype wire

// file: verification/ltcs_fill_station.sv
// Model of the gas filling station answering fill requests.
`timescale 1ns/1ps
`default_nettype none
module ltcs_fill_station #(
  parameter FILL_CYC = 3
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Handshake
  input wire logic fill_req,
  output logic     fill_done
);
  logic [7:0] cnt_reg;
  // Done is raised after the part is filled and dropped with the request.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 8'h00;
      fill_done <= 1'b0;
    end else if (!fill_req) begin
      cnt_reg <= 8'h00;
      fill_done <= 1'b0;
    end else if (cnt_reg == FILL_CYC) begin
      fill_done <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: verification/ltcs_seq_bench.sv
// Self-checking testbench of the leak-test cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "ltcs_regs.vh"
module ltcs_seq_bench;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, high_range_in = 0, seen_req = 0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, leak_rate = 32'h0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, fill_done, fill_req, evac_on, vent_on, pass_out, fail_out, irq;
  int          fails = 0, num_checks = 0, cycles = 0;
  always #25 hclk = ~hclk;
  ltcs_seq #(.TW(16), .TICK_CYC(4)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .high_range_in(high_range_in),
    .leak_rate(leak_rate), .fill_done_in(fill_done), .fill_req(fill_req),
    .evac_on(evac_on), .vent_on(vent_on), .pass_out(pass_out), .fail_out(fail_out),
    .irq(irq));
  ltcs_fill_station #(.FILL_CYC(3)) u_fill (
    .hclk(hclk), .hresetn(hresetn), .fill_req(fill_req), .fill_done(fill_done));
  always @(posedge hclk) begin
    if (fill_req === 1'b1) seen_req <= 1'b1;
    cycles++;
    if (cycles == 40000) begin
      fails++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  // One whole cycle; the spike run shows a high rate early and a low final rate.
  task automatic cyc(input logic fill, input logic peak, input logic spike,
                     input logic [31:0] lim, input logic [1:0] res, input logic req,
                     input logic warn, input logic [31:0] rv);
    logic [31:0] q;
    int          n;
    wr(8'h14, lim);
    leak_rate <= spike ? 32'h10 : 32'h1000;
    seen_req = 1'b0;
    wr(8'h00, {28'h0, 1'b0, peak, fill, 1'b1});
    n = 0;
    while (evac_on !== 1'b1 && n < 100) begin @(posedge hclk); n++; end
    repeat (5) @(posedge hclk);
    high_range_in <= 1'b1;
    if (spike) begin
      while (fill_done !== 1'b1 && n < 400) begin @(posedge hclk); n++; end
      repeat (6) @(posedge hclk);
      leak_rate <= 32'h5000;
      repeat (3) @(posedge hclk);
      leak_rate <= 32'h800;
    end
    while (vent_on !== 1'b1 && n < 600) begin @(posedge hclk); n++; end
    while (vent_on !== 1'b0 && n < 800) begin @(posedge hclk); n++; end
    high_range_in <= 1'b0;
    chk({30'h0, fail_out, pass_out}, {30'h0, res});
    chk({31'h0, seen_req}, {31'h0, req});
    chk({31'h0, n >= 12}, 32'h1);
    rd(8'h08, q);
    chk({30'h0, q[2:1]}, {30'h0, warn, res[1]});
    rd(8'h04, q);
    chk({24'h0, q[15:8]}, {24'h0, warn ? `LTCS_WARN_BG_TMO : 8'h00});
    rd(8'h2C, q);
    chk(q, rv);
  endtask
  // An abort during evacuation vents at once and leaves no result.
  task automatic abort_run;
    int n;
    wr(8'h00, 32'h1);
    n = 0;
    while (evac_on !== 1'b1 && n < 100) begin @(posedge hclk); n++; end
    wr(8'h00, 32'h8);
    while (vent_on !== 1'b1 && n < 200) begin @(posedge hclk); n++; end
    chk({30'h0, fail_out, pass_out}, 32'h0);
    chk({31'h0, evac_on}, 32'h0);
    while (vent_on !== 1'b0 && n < 400) begin @(posedge hclk); n++; end
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [31:0] q;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h10, q);
    chk(q, `LTCS_RST_SETPOINT);
    rd(8'h14, q);
    chk(q, `LTCS_RST_BG_LIMIT);
    rd(8'h18, q);
    chk(q, {16'h0, `LTCS_RST_TIMER});
    rd(8'h3C, q);
    chk(q, 32'h0);
    wr(8'h18, 32'h3);
    wr(8'h1C, 32'h5);
    wr(8'h20, 32'h4);
    wr(8'h24, 32'h40);
    wr(8'h28, 32'h2);
    rd(8'h1C, q);
    chk(q, 32'h5);
    cyc(1'b1, 1'b0, 1'b1, 32'hFFFFFFFF, 2'b01, 1'b1, 1'b0, 32'h800);
    chk({31'h0, irq}, 32'h0);
    wr(8'h0C, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h08, 32'h7);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    cyc(1'b1, 1'b1, 1'b1, 32'hFFFFFFFF, 2'b10, 1'b1, 1'b0, 32'h5000);
    wr(8'h08, 32'h7);
    cyc(1'b0, 1'b1, 1'b0, 32'hFFFFFFFF, 2'b01, 1'b0, 1'b0, 32'h1000);
    wr(8'h08, 32'h7);
    cyc(1'b1, 1'b0, 1'b0, 32'h100, 2'b00, 1'b0, 1'b1, 32'h1000);
    abort_run();
    finish_test();
  end
endmodule
`default_nettype wire
